// >>> verilog/tmcc_pkg.sv
package tmcc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TMCC_CFG_OFS   = 8'h00;
    localparam logic [7:0] TMCC_AMODE_OFS = 8'h04;
    localparam logic [7:0] TMCC_BMODE_OFS = 8'h08;
    localparam logic [7:0] TMCC_CTL_OFS   = 8'h0C;
    localparam logic [7:0] TMCC_STAT_OFS  = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TMCC_MODE_LSB  = 0;
    localparam int TMCC_CMR_BIT   = 2;
    localparam int TMCC_AMS_BIT   = 3;
    localparam int TMCC_AEN_BIT   = 0;
    localparam int TMCC_ASTL_BIT  = 1;
    localparam int TMCC_AEVT_LSB  = 2;
    localparam int TMCC_RTC_BIT   = 4;
    localparam int TMCC_AOTE_BIT  = 5;
    localparam int TMCC_APWML_BIT = 6;
    localparam int TMCC_BEN_BIT   = 8;
    localparam int TMCC_BSTL_BIT  = 9;
    localparam int TMCC_BEVT_LSB  = 10;
    localparam int TMCC_BOTE_BIT  = 13;
    localparam int TMCC_BPWML_BIT = 14;

    // Writable masks and reset values
    localparam logic [31:0] TMCC_CFG_MASK  = 32'h0000_0007;
    localparam logic [31:0] TMCC_MODE_MASK = 32'h0000_000F;
    localparam logic [31:0] TMCC_CTL_MASK  = 32'h0000_6F7F;
    localparam logic [31:0] TMCC_RST_VAL   = 32'h0000_0000;

    // Width configuration codes
    localparam logic [2:0] TMCC_CFG_32    = 3'h0;
    localparam logic [2:0] TMCC_CFG_RTC   = 3'h1;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TMCC_MODE_RSVD    = 2'h0,
        TMCC_MODE_ONESHOT = 2'h1,
        TMCC_MODE_PERIOD  = 2'h2,
        TMCC_MODE_CAPTURE = 2'h3
    } tmcc_mode_t;

    typedef enum logic [1:0] {
        TMCC_EDGE_RISE = 2'h0,
        TMCC_EDGE_FALL = 2'h1,
        TMCC_EDGE_RSVD = 2'h2,
        TMCC_EDGE_BOTH = 2'h3
    } tmcc_edge_t;
endpackage

// >>> verilog/tmcc_half_if.sv
`timescale 1ns/100ps
interface tmcc_half_if;
    import tmcc_pkg::*;
    logic [1:0] mode_field;
    logic       capture_submode_bit;
    logic       alternate_mode_bit;
    logic       enable;
    logic       debug_freeze;
    logic       pwm_invert;
    logic       pwm_raw;
    logic       debug_halt;
    logic       count_run;
    logic       capture_armed;
    logic       edge_count;
    logic       edge_time;
    logic       pwm_sel;
    logic       oneshot;
    logic       periodic;
    logic       pwm_out;
    modport ctrl (
        output mode_field, capture_submode_bit, alternate_mode_bit, enable,
        output debug_freeze, pwm_invert, pwm_raw, debug_halt,
        input  count_run, capture_armed, edge_count, edge_time, pwm_sel,
        input  oneshot, periodic, pwm_out
    );
    modport dec (
        input  mode_field, capture_submode_bit, alternate_mode_bit, enable,
        input  debug_freeze, pwm_invert, pwm_raw, debug_halt,
        output count_run, capture_armed, edge_count, edge_time, pwm_sel,
        output oneshot, periodic, pwm_out
    );
endinterface

// >>> verilog/tmcc_half_dec.sv
`timescale 1ns/100ps
module tmcc_half_dec
    import tmcc_pkg::*;
(
    // Half settings and results
    tmcc_half_if.dec hif
);
    wire tmcc_mode_t mode_w = tmcc_mode_t'(hif.mode_field);
    wire             cap_w  = (mode_w == TMCC_MODE_CAPTURE);
    wire             tmr_w  = (mode_w == TMCC_MODE_ONESHOT) || (mode_w == TMCC_MODE_PERIOD);
    wire             pwm_w  = hif.alternate_mode_bit && !hif.capture_submode_bit
                              && (mode_w == TMCC_MODE_PERIOD);

    assign hif.oneshot    = (mode_w == TMCC_MODE_ONESHOT);
    assign hif.periodic   = (mode_w == TMCC_MODE_PERIOD) && !pwm_w;
    assign hif.edge_count = cap_w && !hif.alternate_mode_bit && !hif.capture_submode_bit;
    assign hif.edge_time  = cap_w && !hif.alternate_mode_bit && hif.capture_submode_bit;
    assign hif.pwm_sel    = pwm_w;
    wire   frozen_w       = hif.debug_freeze && hif.debug_halt;
    assign hif.count_run  = hif.enable && (tmr_w || pwm_w) && !frozen_w;
    assign hif.capture_armed = hif.enable && cap_w && !hif.alternate_mode_bit && !frozen_w;
    assign hif.pwm_out    = hif.pwm_raw ^ hif.pwm_invert;
endmodule

// >>> verilog/tmcc_top.sv
`timescale 1ns/100ps
// Behaviour
// - Timer A mode field 1 is one-shot, 2 periodic, 3 capture, 0 reserved.
// - In split 16-bit setup timer B follows its own mode field with the same codes.
// - The capture submode bit picks edge counting when 0 and edge timing when 1.
// - Alternate mode bit 0 gives capture and 1 gives PWM, with submode 0 and mode 2.
// - In combined 32-bit setup only timer A's mode register counts and B's is ignored.
// - Each mode field is read under the three-bit width configuration field.
// - Timer B edge select 0 is rising, 1 falling, 3 both, 2 reserved.
// - With the freeze bit set timer B stops while the processor is debug halted.
// - The freeze bit has no effect while the processor runs normally.
// - Timer B counts or arms capture only while its enable bit is set.
// - Timer B converter trigger leaves only while its trigger enable bit is set.
// - Unused register bits are read-only and read as zero.
// - Each half's PWM output is passed straight at level bit 0 and inverted at 1.
// - Width code 0 is combined 32-bit, codes 4 to 7 split 16-bit.
module tmcc_top
    import tmcc_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    // Register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // Debug and timer core
    input  wire logic        DEBUG_HALT,
    input  wire logic        A_PWM_RAW,
    input  wire logic        B_PWM_RAW,
    input  wire logic        B_TIMEOUT,
    input  wire logic        B_EDGE_IN,
    // Timer A controls
    output logic             A_COUNT_RUN,
    output logic             A_CAPTURE_ARMED,
    output logic             A_ONESHOT,
    output logic             A_PERIODIC,
    output logic             A_EDGE_COUNT,
    output logic             A_EDGE_TIME,
    output logic             A_PWM_SEL,
    output logic             A_PWM_OUT,
    // Timer B controls
    output logic             B_COUNT_RUN,
    output logic             B_CAPTURE_ARMED,
    output logic             B_ONESHOT,
    output logic             B_PERIODIC,
    output logic             B_EDGE_COUNT,
    output logic             B_EDGE_TIME,
    output logic             B_PWM_SEL,
    output logic             B_PWM_OUT,
    output logic             B_EDGE_EVENT,
    output logic             B_CONV_TRIGGER,
    // Global
    output logic             SPLIT_MODE
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] halt_s_q;
    logic [1:0] edge_s_q;
    logic       edge_prev_q;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            halt_s_q    <= 2'h0;
            edge_s_q    <= 2'h0;
            edge_prev_q <= 1'b0;
        end else begin
            halt_s_q    <= {halt_s_q[0], DEBUG_HALT};
            edge_s_q    <= {edge_s_q[0], B_EDGE_IN};
            edge_prev_q <= edge_s_q[1];
        end
    end
    wire halt_w = halt_s_q[1];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0]  cfg_q;
    logic [3:0]  amode_q;
    logic [3:0]  bmode_q;
    logic [14:0] ctl_q;

    wire sel_cfg   = (REG_ADDR == TMCC_CFG_OFS);
    wire sel_amode = (REG_ADDR == TMCC_AMODE_OFS);
    wire sel_bmode = (REG_ADDR == TMCC_BMODE_OFS);
    wire sel_ctl   = (REG_ADDR == TMCC_CTL_OFS);
    wire sel_stat  = (REG_ADDR == TMCC_STAT_OFS);

    wire [31:0] cfg_wd   = REG_WDATA & TMCC_CFG_MASK;
    wire [31:0] mode_wd  = REG_WDATA & TMCC_MODE_MASK;
    wire [31:0] ctl_wd   = REG_WDATA & TMCC_CTL_MASK;

    // zero reset, write lands on next edge
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q   <= TMCC_RST_VAL[2:0];
            amode_q <= TMCC_RST_VAL[3:0];
            bmode_q <= TMCC_RST_VAL[3:0];
            ctl_q   <= TMCC_RST_VAL[14:0];
        end else if (REG_WR) begin
            if (sel_cfg)   cfg_q   <= cfg_wd[2:0];
            if (sel_amode) amode_q <= mode_wd[3:0];
            if (sel_bmode) bmode_q <= mode_wd[3:0];
            if (sel_ctl)   ctl_q   <= ctl_wd[14:0];
        end
    end

    // ------------------------------------------------------------
    // Width configuration
    // ------------------------------------------------------------
    // config code decode
    wire split_w = cfg_q[2];
    wire comb_w  = (cfg_q == TMCC_CFG_32);
    wire a_live_w = comb_w || split_w;
    wire [3:0] bmode_eff = split_w ? bmode_q : 4'h0;
    wire       b_en_w    = split_w && ctl_q[TMCC_BEN_BIT];

    // ------------------------------------------------------------
    // Half decoders
    // ------------------------------------------------------------
    tmcc_half_if a_if ();
    tmcc_half_if b_if ();

    assign a_if.mode_field          = a_live_w ? amode_q[1:0] : 2'h0;
    assign a_if.capture_submode_bit = amode_q[TMCC_CMR_BIT];
    assign a_if.alternate_mode_bit  = amode_q[TMCC_AMS_BIT];
    assign a_if.enable              = ctl_q[TMCC_AEN_BIT];
    assign a_if.debug_freeze        = ctl_q[TMCC_ASTL_BIT];
    assign a_if.pwm_invert          = ctl_q[TMCC_APWML_BIT];
    assign a_if.pwm_raw             = A_PWM_RAW;
    assign a_if.debug_halt          = halt_w;

    assign b_if.mode_field          = bmode_eff[1:0];
    assign b_if.capture_submode_bit = bmode_eff[TMCC_CMR_BIT];
    assign b_if.alternate_mode_bit  = bmode_eff[TMCC_AMS_BIT];
    assign b_if.enable              = b_en_w;
    assign b_if.debug_freeze        = ctl_q[TMCC_BSTL_BIT];
    assign b_if.pwm_invert          = ctl_q[TMCC_BPWML_BIT];
    assign b_if.pwm_raw             = B_PWM_RAW;
    assign b_if.debug_halt          = halt_w;

    tmcc_half_dec u_dec_a (.hif(a_if.dec));
    tmcc_half_dec u_dec_b (.hif(b_if.dec));

    assign A_COUNT_RUN     = a_if.count_run;
    assign A_CAPTURE_ARMED = a_if.capture_armed;
    assign A_ONESHOT       = a_if.oneshot;
    assign A_PERIODIC      = a_if.periodic;
    assign A_EDGE_COUNT    = a_if.edge_count;
    assign A_EDGE_TIME     = a_if.edge_time;
    assign A_PWM_SEL       = a_if.pwm_sel;
    assign A_PWM_OUT       = a_if.pwm_out;
    assign B_COUNT_RUN     = b_if.count_run;
    assign B_CAPTURE_ARMED = b_if.capture_armed;
    assign B_ONESHOT       = b_if.oneshot;
    assign B_PERIODIC      = b_if.periodic;
    assign B_EDGE_COUNT    = b_if.edge_count;
    assign B_EDGE_TIME     = b_if.edge_time;
    assign B_PWM_SEL       = b_if.pwm_sel;
    assign B_PWM_OUT       = b_if.pwm_out;
    assign SPLIT_MODE      = split_w;

    // ------------------------------------------------------------
    // Timer B edge detect and trigger
    // ------------------------------------------------------------
    wire tmcc_edge_t bevt_w = tmcc_edge_t'(ctl_q[TMCC_BEVT_LSB +: 2]);
    wire rise_w = edge_s_q[1] && !edge_prev_q;
    wire fall_w = !edge_s_q[1] && edge_prev_q;
    logic edge_hit;
    always_comb begin
        unique case (bevt_w)
            TMCC_EDGE_RISE: edge_hit = rise_w;
            TMCC_EDGE_FALL: edge_hit = fall_w;
            TMCC_EDGE_BOTH: edge_hit = rise_w || fall_w;
            TMCC_EDGE_RSVD: edge_hit = 1'b0;
        endcase
    end

    logic edge_ev_q;
    logic trig_q;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            edge_ev_q <= 1'b0;
            trig_q    <= 1'b0;
        end else begin
            edge_ev_q <= edge_hit && b_if.capture_armed;
            trig_q    <= B_TIMEOUT && ctl_q[TMCC_BOTE_BIT];
        end
    end
    assign B_EDGE_EVENT   = edge_ev_q;
    assign B_CONV_TRIGGER = trig_q;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // unused bits read zero
    wire [31:0] cfg_rd  = {29'h0, cfg_q};
    wire [31:0] am_rd   = {28'h0, amode_q};
    wire [31:0] bm_rd   = {28'h0, bmode_q};
    wire [31:0] ctl_rd  = {17'h0, ctl_q};
    wire [31:0] st_rd   = {22'h0, B_CAPTURE_ARMED, B_COUNT_RUN, 6'h0,
                           A_CAPTURE_ARMED, A_COUNT_RUN};
    wire [31:0] rd_mux  = sel_cfg   ? cfg_rd :
                          sel_amode ? am_rd  :
                          sel_bmode ? bm_rd  :
                          sel_ctl   ? ctl_rd :
                          sel_stat  ? st_rd  : 32'h0000_0000;
    logic [31:0] rdata_q;
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= REG_RD ? rd_mux : 32'h0000_0000;
        end
    end
    assign REG_RDATA = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    AST_A_ONESHOT: assert property (
        (a_live_w && amode_q[1:0] == 2'h1) |-> A_ONESHOT && !A_PERIODIC)
        else $error("timer A one-shot decode wrong");
    AST_B_SPLIT: assert property (
        (split_w && bmode_q[1:0] == 2'h1) |-> B_ONESHOT)
        else $error("timer B split mode decode wrong");
    AST_A_SUBMODE: assert property (
        (a_live_w && amode_q == 4'h7) |-> A_EDGE_TIME && !A_EDGE_COUNT)
        else $error("timer A submode decode wrong");
    AST_B_PWM: assert property (
        (split_w && bmode_q == 4'hA) |-> B_PWM_SEL && !B_PERIODIC)
        else $error("timer B PWM select wrong");
    AST_B_IGNORED: assert property (
        comb_w |-> !B_COUNT_RUN && !B_CAPTURE_ARMED && !B_PWM_SEL)
        else $error("timer B active in combined setup");
    AST_B_FREEZE: assert property (
        (ctl_q[TMCC_BSTL_BIT] && halt_w) |-> !B_COUNT_RUN)
        else $error("timer B counted during halt");
    AST_B_NOFREEZE: assert property (
        (!halt_w && b_en_w && bmode_q[1:0] == 2'h2) |-> B_COUNT_RUN)
        else $error("timer B stalled while running");
    AST_B_TRIG: assert property (
        B_CONV_TRIGGER |-> $past(ctl_q[TMCC_BOTE_BIT]) && $past(B_TIMEOUT))
        else $error("converter trigger without enable");
    AST_WRITE: assert property (
        (REG_WR && sel_ctl) |=> (ctl_q == $past(REG_WDATA[14:0] & TMCC_CTL_MASK[14:0]))
        ) else $error("control write not applied");
    AST_RDATA: assert property (
        (REG_RD && sel_ctl) |=> REG_RDATA[31:15] == 17'h0 && !REG_RDATA[12] && !REG_RDATA[7])
        else $error("reserved bits read nonzero");
    AST_PWM_INV: assert property (
        B_PWM_OUT == (B_PWM_RAW ^ ctl_q[TMCC_BPWML_BIT]))
        else $error("timer B PWM level wrong");
    AST_A_PWM_INV: assert property (
        A_PWM_OUT == (A_PWM_RAW ^ ctl_q[TMCC_APWML_BIT]))
        else $error("timer A PWM level wrong");

    // ------------------------------------------------------------
    // Mode decode checks
    // ------------------------------------------------------------
    AST_A_PERIODIC: assert property (
        (a_live_w && amode_q == 4'h2) |-> A_PERIODIC && !A_ONESHOT && !A_PWM_SEL)
        else $error("timer A periodic decode wrong");
    AST_A_CAPTURE: assert property (
        (a_live_w && amode_q[1:0] == 2'h3 && !amode_q[TMCC_AMS_BIT])
        |-> (A_EDGE_COUNT != A_EDGE_TIME))
        else $error("timer A capture decode wrong");
    AST_A_RSVD: assert property (
        (amode_q[1:0] == 2'h0)
        |-> !A_ONESHOT && !A_PERIODIC && !A_COUNT_RUN && !A_CAPTURE_ARMED)
        else $error("timer A active in reserved mode");
    AST_B_COUNT: assert property (
        (split_w && bmode_q == 4'h3) |-> B_EDGE_COUNT && !B_EDGE_TIME)
        else $error("timer B submode decode wrong");
    AST_A_PWM: assert property (
        (a_live_w && amode_q == 4'hA) |-> A_PWM_SEL && !A_PERIODIC)
        else $error("timer A PWM select wrong");
    AST_A_DEAD: assert property (
        !a_live_w
        |-> !A_ONESHOT && !A_PERIODIC && !A_COUNT_RUN && !A_CAPTURE_ARMED)
        else $error("timer A active in unsupported width setup");

    // ------------------------------------------------------------
    // Control checks
    // ------------------------------------------------------------
    AST_EDGE_RISE: assert property (
        (B_CAPTURE_ARMED && bevt_w == TMCC_EDGE_RISE && rise_w) |=> B_EDGE_EVENT)
        else $error("timer B rising edge missed");
    AST_EDGE_RSVD: assert property (
        (bevt_w == TMCC_EDGE_RSVD) |=> !B_EDGE_EVENT)
        else $error("timer B event on reserved edge code");
    AST_B_OFF: assert property (
        !ctl_q[TMCC_BEN_BIT] |-> !B_COUNT_RUN && !B_CAPTURE_ARMED)
        else $error("timer B active while disabled");
    AST_TRIG_OFF: assert property (
        !ctl_q[TMCC_BOTE_BIT] |=> !B_CONV_TRIGGER)
        else $error("converter trigger while disabled");

    // ------------------------------------------------------------
    // Reset and bus checks
    // ------------------------------------------------------------
    AST_RESET: assert property (
        !$past(rst_n) |-> cfg_q == 3'h0 && amode_q == 4'h0 && bmode_q == 4'h0
                          && ctl_q == 15'h0 && REG_RDATA == 32'h0000_0000)
        else $error("registers not cleared by reset");
    AST_RDATA_IDLE: assert property (
        !$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
        else $error("read data outside read cycle");
    AST_BMODE_WRITE: assert property (
        (REG_WR && sel_bmode) |=> bmode_q == $past(REG_WDATA[3:0]))
        else $error("timer B mode write not applied");

    COV_PWM:   cover property (B_PWM_SEL && B_COUNT_RUN);
    COV_FRZ:   cover property (ctl_q[TMCC_BSTL_BIT] && halt_w && b_en_w);
    COV_EDGE:  cover property (B_EDGE_EVENT);
    COV_TRIG:  cover property (B_CONV_TRIGGER);
    COV_ETIME: cover property (B_EDGE_TIME && B_CAPTURE_ARMED);
endmodule

// >>> sim/tmcc_tb.sv
`timescale 1ns/100ps
module tb;
    import tmcc_pkg::*;
    logic        mclk, rstn, reg_wr, reg_rd, debug_halt;
    logic        a_pwm_raw, b_pwm_raw, b_timeout, b_edge_in;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    wire  [6:0]  a_o, b_o;
    logic        a_pwm_out, b_pwm_out, b_edge_event, b_conv_trigger, split_mode;
    int          fails, checked, cycles, seed, halt, mcfg, ma, mb, mctl;
    logic [6:0]  exp_a, exp_b;
    // Legal mode settings: one-shot, periodic, edge count, edge time, PWM, reserved
    int          tm[6] = '{1, 2, 3, 3, 2, 0};
    int          tc[6] = '{0, 0, 0, 1, 0, 0};
    int          ta[6] = '{0, 0, 0, 0, 1, 0};

    tmcc_top dut (
        .MCLK(mclk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .DEBUG_HALT(debug_halt), .A_PWM_RAW(a_pwm_raw), .B_PWM_RAW(b_pwm_raw),
        .B_TIMEOUT(b_timeout), .B_EDGE_IN(b_edge_in),
        .A_COUNT_RUN(a_o[6]), .A_CAPTURE_ARMED(a_o[5]), .A_ONESHOT(a_o[4]),
        .A_PERIODIC(a_o[3]), .A_EDGE_COUNT(a_o[2]), .A_EDGE_TIME(a_o[1]),
        .A_PWM_SEL(a_o[0]), .A_PWM_OUT(a_pwm_out),
        .B_COUNT_RUN(b_o[6]), .B_CAPTURE_ARMED(b_o[5]), .B_ONESHOT(b_o[4]),
        .B_PERIODIC(b_o[3]), .B_EDGE_COUNT(b_o[2]), .B_EDGE_TIME(b_o[1]),
        .B_PWM_SEL(b_o[0]), .B_PWM_OUT(b_pwm_out), .B_EDGE_EVENT(b_edge_event),
        .B_CONV_TRIGGER(b_conv_trigger), .SPLIT_MODE(split_mode)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fails = fails + 1;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Checking and model
    // ------------------------------------------------------------
    task automatic close_out;
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [6:0] half(int m, int c, int a, int en, int frz);
        logic act;
        act = (en != 0) && !((frz != 0) && (halt != 0));
        return {act && (m == 1 || m == 2), act && m == 3 && a == 0, m == 1,
                m == 2 && a == 0, m == 3 && c == 0 && a == 0, m == 3 && c == 1 && a == 0,
                m == 2 && a == 1};
    endfunction

    task automatic check_outs;
        int am;
        am = (mcfg >= 1 && mcfg <= 3) ? 0 : ma;
        exp_a = half(am & 3, (am >> 2) & 1, (am >> 3) & 1, mctl & 1, (mctl >> 1) & 1);
        exp_b = (mcfg >= 4) ? half(mb & 3, (mb >> 2) & 1, (mb >> 3) & 1,
                                   (mctl >> 8) & 1, (mctl >> 9) & 1) : 7'h00;
        chk(a_o, exp_a);
        chk(b_o, exp_b);
        chk(a_pwm_out, a_pwm_raw ^ mctl[6]);
        if (mcfg >= 4) chk(b_pwm_out, b_pwm_raw ^ mctl[14]);
        chk(split_mode, mcfg[2]);
        chk(b_edge_event, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic read_all;
        rd_chk(TMCC_CFG_OFS, mcfg);
        rd_chk(TMCC_AMODE_OFS, ma);
        rd_chk(TMCC_BMODE_OFS, mb);
        rd_chk(TMCC_CTL_OFS, mctl);
        rd_chk(TMCC_STAT_OFS, {exp_b[5], exp_b[6], 6'h00, exp_a[5], exp_a[6]});
        rd_chk(8'h14, 32'h0000_0000);
    endtask

    // Counts edge events over a window after one input change
    task automatic edge_win(logic lvl, int exp);
        int n;
        n = 0;
        @(posedge mclk);
        b_edge_in <= lvl;
        repeat (8) begin
            @(posedge mclk);
            #1 n = n + (b_edge_event === 1'b1);
        end
        chk(n, exp);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int c, ai, bi, t, w;
        seed = 32'hdd27bf2e;
        {rstn, reg_wr, reg_rd, debug_halt, a_pwm_raw, b_pwm_raw} = 6'h00;
        {b_timeout, b_edge_in, reg_addr, reg_wdata} = 42'h0;
        {fails, checked, cycles, halt, mcfg, ma, mb, mctl} = '0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check_outs();
        read_all();
        for (int i = 0; i < 40; i++) begin
            wr(TMCC_CTL_OFS, 32'h0);
            mctl = 0;
            halt = $random(seed) & 1;
            debug_halt <= 1'(halt);
            c = $random(seed) & 7;
            if (c == 2 || c == 3) c = 4 + i % 4;
            ai = ($random(seed) & 32'hFF) % 6;
            if (c == 0 && ai >= 2 && ai <= 4) ai = 1;
            bi = ($random(seed) & 32'hFF) % 6;
            w = ($random(seed) & ~32'h7) | c;
            wr(TMCC_CFG_OFS, w);
            mcfg = w & 7;
            w = ($random(seed) & ~32'hF) | tm[ai] | (tc[ai] << 2) | (ta[ai] << 3);
            wr(TMCC_AMODE_OFS, w);
            ma = w & 15;
            w = ($random(seed) & ~32'hF) | tm[bi] | (tc[bi] << 2) | (ta[bi] << 3);
            wr(TMCC_BMODE_OFS, w);
            mb = w & 15;
            w = $random(seed);
            wr(TMCC_CTL_OFS, w);
            mctl = w & 32'h6F7F;
            #1 check_outs();
            read_all();
            wr(8'h20, $random(seed));
            read_all();
            for (int k = 0; k < 5; k++) begin
                @(posedge mclk);
                t = $random(seed) & 1;
                b_timeout <= 1'(t);
                a_pwm_raw <= 1'($random(seed));
                b_pwm_raw <= 1'($random(seed));
                @(posedge mclk);
                #1;
                if (mcfg >= 4) chk(b_conv_trigger, t & mctl[13]);
                check_outs();
            end
        end
        // second reset in mid-run clears every field
        rstn <= 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        {mcfg, ma, mb, mctl} = '0;
        repeat (3) @(posedge mclk);
        #1 check_outs();
        read_all();
        // Edge selection on the capture input, all four codes
        halt = 0;
        debug_halt <= 1'b0;
        wr(TMCC_CFG_OFS, 32'h4);
        wr(TMCC_BMODE_OFS, 32'h3);
        for (int s = 0; s < 4; s++) begin
            wr(TMCC_CTL_OFS, 32'h0);
            wr(TMCC_CTL_OFS, 32'h100 | (s << 10));
            repeat (6) @(posedge mclk);
            edge_win(1'b1, s == 0 || s == 3);
            edge_win(1'b0, s == 1 || s == 3);
        end
        close_out();
    end
endmodule
